// file: hdl/odac_pkg.sv
// package of constants for the octal dac serial register bank
package odac_pkg;
  localparam int          WORD_BITS     = 16;
  localparam int          DATA_BITS     = 12;
  localparam int          ADDR_BITS     = 4;
  localparam int          CODE_BITS     = 8;
  localparam int          NUM_DACS      = 8;
  localparam int          NUM_PAIRS     = 4;
  localparam int          CODE_MSB_POS  = 11;
  localparam int          CODE_LSB_POS  = 4;
  localparam int          CNT_BITS      = 5;
  // register addresses
  localparam logic [3:0]  ADDR_DAC_LAST = 4'h7;
  localparam logic [3:0]  ADDR_DEV_CTRL = 4'h8;
  localparam logic [3:0]  ADDR_PAIR_CTRL = 4'h9;
  localparam logic [3:0]  ADDR_PRESET   = 4'hA;
  localparam logic [3:0]  ADDR_RESERVED = 4'hB;
  localparam logic [3:0]  ADDR_PAIR_AB  = 4'hC;
  localparam logic [3:0]  ADDR_PAIR_GH  = 4'hF;
  // field positions in device control
  localparam int          DEV_PD_POS    = 4;
  localparam int          DEV_DOUT_POS  = 3;
  localparam int          DEV_FMT_POS   = 0;
  // field positions in pair control
  localparam int          PAIR_PD_LSB   = 4;
  localparam int          PAIR_SPD_LSB  = 0;
  // reset values, format msb flip mask and last bit count
  localparam logic [7:0]  CODE_RST      = 8'h00;
  localparam logic [3:0]  PAIR_RST      = 4'h0;
  localparam logic [7:0]  CODE_MSB_FLIP = 8'h80;
  localparam logic [4:0]  CNT_LAST      = 5'h10;
endpackage

// file: hdl/odac_regs.sv
// serial register bank of an octal 8-bit dac
`timescale 1ns/1ps
// Notes on behaviour
// - address 8 holds full power down D4, dout enable D3, format D0; reset 0.
// - full power down bit one powers whole device down, zero normal.
// - format bit zero straight binary, one two's complement.
// - address 9 holds pair power downs D7-D4 and speeds D3-D0, GH high.
// - pair power down disables both output amplifiers of that pair.
// - pair speed one fast, zero slow low-power for both dacs.
// - address 10 stores preset; preset pin low applies it to all dacs.
// - preset resets to zero so unwritten preset gives zero scale in straight binary, midscale in two's complement.
// - addresses 12-15 load code to first dac, complement to second.
// - 12 is A/B, 13 C/D, 14 E/F, 15 G/H.
// - frame is 16 bits, address in top four, msb first, 12 data.
// - code is D11-D4, reaches converter while load pin low and preset pin high.
// - serial output repeats input delayed sixteen serial clocks when enabled.
// - power-on reset clears dac code registers to zero.
module odac_regs
  import odac_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // serial port pins
  input  wire logic                    sclk_i,
  input  wire logic                    sdin_i,
  input  wire logic                    frame_sync_i,
  input  wire logic                    preset_pin_n_i,
  input  wire logic                    load_pin_n_i,
  output logic                         sdout_o,
  // converter side
  output logic [odac_pkg::NUM_DACS*odac_pkg::CODE_BITS-1:0] dac_code_o,
  output logic                         full_power_down_o,
  output logic                         code_format_select_o,
  output logic [odac_pkg::NUM_PAIRS-1:0] pair_power_down_o,
  output logic [odac_pkg::NUM_PAIRS-1:0] pair_speed_o
);
  import odac_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic       sclk_d_ff;
  logic       sclk_fall;
  logic       sclk_rise;

  // two stages for every pin; only the second stage feeds logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 4'hF;
      sync_ff <= 4'hF;
    end else begin
      meta_ff <= {load_pin_n_i, preset_pin_n_i, frame_sync_i, sdin_i};
      sync_ff <= meta_ff;
    end
  end

  wire logic s_din    = sync_ff[0];
  wire logic s_fs     = sync_ff[1];
  wire logic s_pre_n  = sync_ff[2];
  wire logic s_load_n = sync_ff[3];

  logic sclk_meta_ff;
  logic sclk_sync_ff;
  // reset to the parked-high level so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_meta_ff <= 1'b1;
      sclk_sync_ff <= 1'b1;
      sclk_d_ff    <= 1'b1;
    end else begin
      sclk_meta_ff <= sclk_i;
      sclk_sync_ff <= sclk_meta_ff;
      sclk_d_ff    <= sclk_sync_ff;
    end
  end
  assign sclk_fall = sclk_d_ff & ~sclk_sync_ff;
  assign sclk_rise = ~sclk_d_ff & sclk_sync_ff;

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_ff;
  logic [CNT_BITS-1:0]  cnt_ff;
  logic                 fs_d_ff;
  logic                 wr_stb_ff;

  // data sampled on falling sclk, msb first; frame starts on fs low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_ff <= '0;
      cnt_ff   <= '0;
      fs_d_ff  <= 1'b1;
      wr_stb_ff <= 1'b0;
    end else begin
      fs_d_ff   <= s_fs;
      wr_stb_ff <= 1'b0;
      if (fs_d_ff && !s_fs) begin
        cnt_ff <= '0;
      end else if (sclk_fall && cnt_ff != CNT_LAST) begin
        shift_ff <= {shift_ff[WORD_BITS-2:0], s_din};
        cnt_ff   <= cnt_ff + 5'h01;
        if (cnt_ff == CNT_LAST - 5'h01) begin
          wr_stb_ff <= 1'b1; // a short frame is never written
        end
      end
    end
  end

  wire logic [ADDR_BITS-1:0] w_addr = shift_ff[WORD_BITS-1:DATA_BITS];
  wire logic [DATA_BITS-1:0] w_data = shift_ff[DATA_BITS-1:0];
  wire logic [CODE_BITS-1:0] w_code = w_data[CODE_MSB_POS:CODE_LSB_POS];

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic [CODE_BITS-1:0] code_ff [NUM_DACS];
  logic [CODE_BITS-1:0] preset_ff;
  logic                 pd_ff;
  logic                 dout_en_ff;
  logic                 fmt_ff;
  logic [NUM_PAIRS-1:0] pair_pd_ff;
  logic [NUM_PAIRS-1:0] pair_spd_ff;

  // control and preset registers; reserved bits and address 11 dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_ff       <= 1'b0;
      dout_en_ff  <= 1'b0;
      fmt_ff      <= 1'b0;
      pair_pd_ff  <= PAIR_RST;
      pair_spd_ff <= PAIR_RST;
      preset_ff   <= CODE_RST;
    end else if (wr_stb_ff) begin
      unique case (w_addr)
        ADDR_DEV_CTRL: begin
          pd_ff      <= w_data[DEV_PD_POS];
          dout_en_ff <= w_data[DEV_DOUT_POS];
          fmt_ff     <= w_data[DEV_FMT_POS];
        end
        ADDR_PAIR_CTRL: begin
          pair_pd_ff  <= w_data[PAIR_PD_LSB +: NUM_PAIRS];
          pair_spd_ff <= w_data[PAIR_SPD_LSB +: NUM_PAIRS];
        end
        ADDR_PRESET: preset_ff <= w_code;
        default: ;
      endcase
    end
  end

  // per-dac code registers: direct addresses and complement pairs
  genvar g;
  generate
    for (g = 0; g < NUM_DACS; g++) begin : g_dac
      localparam logic [3:0] MY_ADDR   = 4'(g);
      localparam logic [3:0] PAIR_ADDR = 4'(ADDR_PAIR_AB + (g / 2));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          code_ff[g] <= CODE_RST;
        end else if (wr_stb_ff) begin
          if (w_addr == MY_ADDR) begin
            code_ff[g] <= w_code;
          end else if (w_addr == PAIR_ADDR) begin
            // even dac gets code, odd partner its complement
            code_ff[g] <= (g % 2 == 0) ? w_code : ~w_code;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // daisy-chain output
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] chain_ff;
  logic                 sdout_ff;

  // 16 stage delay stepped by the sampling edge; dout shifts on rising sclk
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_ff <= '0;
      sdout_ff <= 1'b0;
    end else begin
      if (sclk_fall) begin
        chain_ff <= {chain_ff[WORD_BITS-2:0], s_din};
      end
      if (sclk_rise) begin
        sdout_ff <= dout_en_ff & chain_ff[WORD_BITS-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // converter inputs
  // ----------------------------------------------------------------
  logic [NUM_DACS*CODE_BITS-1:0] conv_ff;
  logic                          fpd_ff;
  logic                          fmt_o_ff;
  logic [NUM_PAIRS-1:0]          ppd_o_ff;
  logic [NUM_PAIRS-1:0]          spd_o_ff;

  // code to the converter: preset has priority, then load-pin gated code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_DACS; i++) begin
        if (!s_pre_n) begin
          conv_ff[i*CODE_BITS +: CODE_BITS] <= preset_ff ^ (fmt_ff ? CODE_MSB_FLIP : CODE_RST);
        end else if (!s_load_n) begin
          conv_ff[i*CODE_BITS +: CODE_BITS] <= code_ff[i] ^ (fmt_ff ? CODE_MSB_FLIP : CODE_RST);
        end
      end
    end
  end

  // power and speed controls registered to the analogue side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fpd_ff   <= 1'b0;
      fmt_o_ff <= 1'b0;
      ppd_o_ff <= PAIR_RST;
      spd_o_ff <= PAIR_RST;
    end else begin
      fpd_ff   <= pd_ff;
      fmt_o_ff <= fmt_ff;
      ppd_o_ff <= pair_pd_ff | {NUM_PAIRS{pd_ff}};
      spd_o_ff <= pair_spd_ff;
    end
  end

  assign dac_code_o           = conv_ff;
  assign full_power_down_o    = fpd_ff;
  assign code_format_select_o = fmt_o_ff;
  assign pair_power_down_o    = ppd_o_ff;
  assign pair_speed_o         = spd_o_ff;
  assign sdout_o              = sdout_ff;
endmodule

// file: verification/odac_host_model.sv
// host serial port model that frames words into the dac register bank
`timescale 1ns/1ps
module odac_host_model (
  // clock
  input  wire logic clk_i,
  // serial pins
  output logic      sclk_o,
  output logic      sdin_o,
  output logic      frame_sync_o
);
  // idle: serial clock parked high, sync high
  initial begin
    sclk_o = 1'b1;
    sdin_o = 1'b0;
    frame_sync_o = 1'b1;
  end
  // one word, msb first; data set while clock high, taken on its fall
  task automatic send(input logic [15:0] w);
    frame_sync_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdin_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
    end
    frame_sync_o = 1'b1;
    sdin_o = ~sdin_o; // released data must not look held
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// file: verification/odac_regs_assertions.sv
// port checker for the octal dac register bank
`timescale 1ns/1ps
module odac_regs_assertions
  import odac_pkg::*;
(
  // clock, reset and pins
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sclk_i,
  input wire logic        preset_pin_n_i,
  input wire logic        load_pin_n_i,
  // design outputs
  input wire logic        sdout_o,
  input wire logic [63:0] dac_code_o,
  input wire logic        full_power_down_o,
  input wire logic        code_format_select_o,
  input wire logic [3:0]  pair_power_down_o,
  input wire logic [3:0]  pair_speed_o
);
  logic       sclk_ff;
  logic [3:0] fall_ff;
  logic [3:0] rise_ff;
  logic [9:0] ctrl;
  assign ctrl = {full_power_down_o, code_format_select_o, pair_power_down_o, pair_speed_o};
  // clocks since each serial edge, saturating; a write lands within 6
  always_ff @(posedge clk_i) begin
    sclk_ff <= sclk_i;
    fall_ff <= (rst_i || (sclk_ff && !sclk_i)) ? 4'h0 : fall_ff + {3'h0, fall_ff != 4'hF};
    rise_ff <= (rst_i || (!sclk_ff && sclk_i)) ? 4'h0 : rise_ff + {3'h0, rise_ff != 4'hF};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_codes_a: assert property ($fell(rst_i) |-> dac_code_o == 64'h0 && !sdout_o)
    else $error("codes not clear after reset");
  reset_ctrl_a: assert property ($fell(rst_i) |-> ctrl == 10'h000)
    else $error("control not clear after reset");
  pd_pairs_a: assert property (full_power_down_o |-> &pair_power_down_o)
    else $error("pairs up during full power down");
  preset_all_a: assert property (!preset_pin_n_i [*4] |-> dac_code_o == {8{dac_code_o[7:0]}})
    else $error("codes differ under preset");
  codes_hold_a: assert property ((load_pin_n_i && preset_pin_n_i) [*5] |-> $stable(dac_code_o))
    else $error("codes moved with load high");
  ctrl_quiet_a: assert property (fall_ff > 4'hB |-> $stable(ctrl))
    else $error("control moved without a frame");
  dout_quiet_a: assert property (rise_ff > 4'h7 |-> $stable(sdout_o))
    else $error("serial out moved off clock");
  preset_hold_a: assert property ((!preset_pin_n_i [*5] ##0 fall_ff > 4'hB) |-> $stable(dac_code_o))
    else $error("preset codes moved");
endmodule
bind odac_regs odac_regs_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
  .preset_pin_n_i(preset_pin_n_i), .load_pin_n_i(load_pin_n_i), .sdout_o(sdout_o), .dac_code_o(dac_code_o),
  .full_power_down_o(full_power_down_o), .code_format_select_o(code_format_select_o),
  .pair_power_down_o(pair_power_down_o), .pair_speed_o(pair_speed_o));

// file: verification/octal_dac_control_registers_tb.sv
// self-checking bench for the octal dac register bank
`timescale 1ns/1ps
module octal_dac_control_registers_tb;
  import odac_pkg::*;
  logic        clk, rst, sclk, sdin, fs, pre_n, load_n, sdout, fpd, fmt;
  logic [63:0] code, snap;
  logic [3:0]  ppd, pspd;
  logic [7:0]  m_code [8];
  logic [7:0]  m_pre;
  logic [11:0] m_c0, m_c1;
  logic [15:0] w1;
  int          errors, tests_run;
  logic [15:0] corner [8] = '{16'hCFF0, 16'hD120, 16'hE7F0, 16'hF000, 16'h8FF1, 16'h9FA5, 16'hA5A0, 16'hBFFF};
  odac_regs i_dut (.clk_i(clk), .rst_i(rst), .sclk_i(sclk), .sdin_i(sdin), .frame_sync_i(fs),
    .preset_pin_n_i(pre_n), .load_pin_n_i(load_n), .sdout_o(sdout), .dac_code_o(code),
    .full_power_down_o(fpd), .code_format_select_o(fmt), .pair_power_down_o(ppd), .pair_speed_o(pspd));
  odac_host_model i_host (.clk_i(clk), .sclk_o(sclk), .sdin_o(sdin), .frame_sync_o(fs));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (100000) @(negedge clk);
    errors++;
    conclude();
  end
  function automatic logic [63:0] exp_code(input logic pre_low);
    logic [63:0] r;
    for (int i = 0; i < 8; i++)
      r[8*i +: 8] = (pre_low ? m_pre : m_code[i]) ^ {m_c0[0], 7'h00};
    return r;
  endfunction
  function automatic logic [63:0] exp_ctrl();
    return {54'h0, m_c0[4], m_c0[0], m_c1[7:4] | {4{m_c0[4]}}, m_c1[3:0]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic check_all();
    chk("dac_code", exp_code(!pre_n), code);
    chk("control", exp_ctrl(), {54'h0, fpd, fmt, ppd, pspd});
  endtask
  // send a word and track what it should change; address 11 changes nothing
  task automatic put(input logic [15:0] w);
    i_host.send(w);
    case (w[15:12])
      4'h8: m_c0 = w[11:0];
      4'h9: m_c1 = w[11:0];
      4'hA: m_pre = w[11:4];
      4'hB: ;
      4'hC, 4'hD, 4'hE, 4'hF: begin
        m_code[2*w[13:12]] = w[11:4];
        m_code[2*w[13:12]+1] = ~w[11:4];
      end
      default: m_code[w[14:12]] = w[11:4];
    endcase
  endtask
  task automatic conclude();
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence: reset, corners, random frames, load freeze, daisy chain
  initial begin
    errors = 0;
    tests_run = 0;
    {rst, pre_n, load_n} = 3'b110;
    m_code = '{default: 8'h00};
    {m_pre, m_c0, m_c1} = 32'h0;
    void'($urandom(32'h1b8a));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check_all();
    pre_n = 1'b0;
    repeat (6) @(negedge clk);
    check_all();
    foreach (corner[k]) begin
      pre_n = (k != 7);
      put(corner[k]);
      check_all();
    end
    for (int n = 0; n < 40; n++) begin
      pre_n = ($urandom_range(0, 3) != 0);
      w1 = 16'($urandom);
      if (!w1[15]) w1[3:1] = 3'h0;
      put(w1);
      check_all();
    end
    pre_n = 1'b1;
    repeat (6) @(negedge clk);
    snap = exp_code(1'b0);
    chk("before freeze", snap, code);
    load_n = 1'b1;
    put(16'h3A50);
    chk("frozen", snap, code);
    load_n = 1'b0;
    repeat (6) @(negedge clk);
    check_all();
    put(16'h8008);
    w1 = {4'hB, 12'($urandom)};
    put(w1);
    fork
      i_host.send(16'hB5C3);
      for (int k = 15; k >= 0; k--) begin
        @(negedge sclk);
        chk("sdout", {63'h0, w1[k]}, {63'h0, sdout});
      end
    join
    put(16'h8000);
    chk("sdout off", 64'h0, {63'h0, sdout});
    // mid-run reset must clear everything written so far
    put(16'h8008);
    put(16'h90FF);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    m_code = '{default: 8'h00};
    {m_pre, m_c0, m_c1} = 32'h0;
    repeat (4) @(negedge clk);
    check_all();
    chk("sdout reset", 64'h0, {63'h0, sdout});
    conclude();
  end
endmodule
